// >>> sim/psp_front.sv
// Optical front end model feeding raw samples to the processing block
`timescale 1ns/1ps

module psp_front (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Scene set by the bench
  input wire logic meas_tick,
  input wire logic signed [31:0] base,
  input wire logic signed [31:0] step,
  input wire logic ok_in,
  input wire logic [6:0] q_in,
  input wire logic [15:0] d_in,
  // Raw sample lines
  output logic signed [31:0] raw_pos,
  output logic raw_ok,
  output logic [6:0] raw_quality,
  output logic [15:0] raw_dist
);
  logic signed [31:0] acc_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= 32'sh0;
    end else if (meas_tick) begin
      acc_r <= acc_r + step;
    end
  end

  // No reading: junk on the lines, so a held value must come from the block
  assign raw_pos = ok_in ? base + acc_r : ~(base + acc_r);
  assign raw_ok = ok_in;
  assign raw_quality = q_in;
  assign raw_dist = d_in;
endmodule : psp_front

// >>> sim/psp_proc_test.sv
// Self-checking bench for the position and speed processing block
`timescale 1ns/1ps

module psp_proc_test import psp_pkg::*;;
  localparam int MSC = 20;
  localparam logic [31:0] P0 = 32'h1E078;
  localparam logic [31:0] P1 = 32'h1E460;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, lfsr_r;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic meas_tick, raw_ok, preset_in, out_upd, err_out, qual_warn, qual_off, ok_in;
  logic signed [31:0] raw_pos, pos_out, spd_out, base, step;
  logic [6:0] raw_quality, qual_out, q_in;
  logic [15:0] raw_dist, dist_out, d_in;
  logic [65:0] notes[$];
  logic [65:0] nt;
  int n_errors, total_checks, upd_gap;

  psp_proc #(.MS_CYC(MSC)) dut_u (.*);
  psp_front front_u (.*);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic results;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Requests move right after a rising edge and stand until taken there
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, a > 8'h3C ? RESP_SLVERR : RESP_OKAY);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF);
    notes.push_back({(a > 8'h3C) ? RESP_SLVERR : RESP_OKAY, m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
  endtask : rd

  // Waits n samples, then lets the three-cycle output pipeline settle
  task automatic tk(input int n);
    repeat (n) begin
      do @(negedge aclk); while (!meas_tick);
    end
    repeat (5) @(posedge aclk);
  endtask : tk

  // Outputs refresh two edges after the sampling edge
  always @(posedge aclk) begin
    upd_gap <= meas_tick ? 1 : upd_gap + 1;
    if (out_upd) begin
      chk(upd_gap, 32'h3);
    end
    if (s_axi_rvalid && s_axi_rready) begin
      nt = notes.pop_front();
      chk(s_axi_rdata & nt[63:32], nt[31:0]);
      chk(s_axi_rresp, nt[65:64]);
    end
  end

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  initial begin
    #(25 * MSC * 400);
    n_errors++;
    results();
  end

  initial begin
    logic [6:0] qs[4];
    int cyc;
    qs = '{7'h63, 7'h32, 7'h14, 7'h00};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, preset_in} = 5'h0;
    {s_axi_bready, s_axi_rready, ok_in} = 3'h7;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    base = P0;
    step = 32'sh0;
    q_in = 7'h64;
    lfsr_r = 32'h61E4;
    d_in = lfsr_r[15:0];
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_DEPTH, 32'h8);
    rd(ADDR_AVG, 32'h8);
    rd(ADDR_QTH, 32'h1E3C);
    rd(8'h40, 32'h0);
    wr(8'h44, 32'h1);
    wr(ADDR_POS, 32'h5);
    wr(ADDR_PERR, 32'hBAD);
    wr(ADDR_EDLY, 32'h3);
    do @(negedge aclk); while (!meas_tick);
    cyc = 0;
    do begin
      @(negedge aclk);
      cyc++;
    end while (!meas_tick);
    chk(cyc, MSC);
    @(posedge aclk);
    wr(ADDR_DEPTH, 32'h4);
    tk(8);
    rd(ADDR_POS, P0);
    base <= P1;
    tk(2);
    rd(ADDR_POS, P0 + 32'h1F4);
    tk(2);
    rd(ADDR_POS, P1);
    tk(4);
    // Four 250-count steps and four still samples in the 8 ms window
    rd(ADDR_SPD, 32'h4E2);
    for (int i = 1; i < 4; i++) begin
      wr(ADDR_RES, i);
      tk(1);
      rd(ADDR_POS, P1 / (10 ** i));
    end
    wr(ADDR_FPD, 32'h7);
    wr(ADDR_RES, 32'h4);
    tk(1);
    rd(ADDR_POS, P1 / 7);
    wr(ADDR_OFS, 32'h5);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_RES, 32'h0);
    tk(1);
    rd(ADDR_POS, P1 + 32'h1F4);
    wr(ADDR_RES, 32'h2);
    tk(1);
    rd(ADDR_POS, 32'h4DD);
    wr(ADDR_RES, 32'h0);
    wr(ADDR_PRE, 32'h7);
    wr(ADDR_CTRL, 32'h3);
    preset_in <= 1'b1;
    tk(1);
    preset_in <= 1'b0;
    rd(ADDR_POS, 32'h2BC);
    wr(ADDR_PRE, 32'h9);
    wr(ADDR_CTRL, 32'h13);
    tk(1);
    rd(ADDR_POS, 32'h384);
    rd(ADDR_CTRL, 32'h3);
    wr(ADDR_CTRL, 32'h0);
    tk(1);
    rd(ADDR_DIST, 32'h0);
    wr(ADDR_CTRL, 32'h4);
    tk(1);
    rd(ADDR_POS, 32'((64'(P1) * POS_MUL_IN) >> 16));
    wr(ADDR_CTRL, 32'h8);
    repeat (2) begin
      lfsr_r = lfsr(lfsr_r);
      d_in <= lfsr_r[15:0];
      tk(1);
      chk(dist_out, d_in);
    end
    wr(ADDR_CTRL, 32'h0);
    foreach (qs[i]) begin
      q_in <= qs[i];
      tk(1);
      chk(qual_out, qs[i]);
      chk(qual_warn, qs[i] < 7'h3C);
      chk(qual_off, qs[i] < 7'h1E);
      rd(ADDR_STAT, {qs[i], 3'h0, qs[i] < 7'h1E, qs[i] < 7'h3C, 2'h0}, 32'h3F8C);
      rd(ADDR_POS, P1);
    end
    q_in <= 7'h64;
    ok_in <= 1'b0;
    tk(2);
    chk(err_out, 1'b0);
    rd(ADDR_POS, P1);
    ok_in <= 1'b1;
    tk(1);
    ok_in <= 1'b0;
    tk(3);
    chk(err_out, 1'b0);
    tk(2);
    chk(err_out, 1'b1);
    rd(ADDR_POS, 32'hBAD);
    ok_in <= 1'b1;
    step <= 32'shA;
    tk(24);
    chk(err_out, 1'b0);
    wr(ADDR_FSD, 32'h4);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_RES, i << 4);
      tk(1);
      rd(ADDR_SPD, (i == 3) ? 32'h19 : 32'h64 / (10 ** i));
    end
    // Let the monitor take the last answer before the verdict
    @(posedge aclk);
    chk(notes.size(), 32'h0);
    results();
  end
endmodule : psp_proc_test

// >>> verilog/psp_pkg.sv
// Constants for the position and speed output processing block
package psp_pkg;
  // Timing
  localparam int CLK_FREQ_HZ = 40_000_000;
  localparam int MEAS_PERIOD_MS = 1;
  localparam int MS_CYCLES = CLK_FREQ_HZ / 1000 * MEAS_PERIOD_MS;
  // Register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_RES = 8'h04;
  localparam logic [7:0] ADDR_DEPTH = 8'h08;
  localparam logic [7:0] ADDR_AVG = 8'h0C;
  localparam logic [7:0] ADDR_OFS = 8'h10;
  localparam logic [7:0] ADDR_PRE = 8'h14;
  localparam logic [7:0] ADDR_EDLY = 8'h18;
  localparam logic [7:0] ADDR_PERR = 8'h1C;
  localparam logic [7:0] ADDR_SERR = 8'h20;
  localparam logic [7:0] ADDR_QTH = 8'h24;
  localparam logic [7:0] ADDR_FPD = 8'h28;
  localparam logic [7:0] ADDR_FSD = 8'h2C;
  localparam logic [7:0] ADDR_STAT = 8'h30;
  localparam logic [7:0] ADDR_POS = 8'h34;
  localparam logic [7:0] ADDR_SPD = 8'h38;
  localparam logic [7:0] ADDR_DIST = 8'h3C;
  // Field positions
  localparam int CTRL_OFS_EN = 0;
  localparam int CTRL_PRE_EN = 1;
  localparam int CTRL_INCH = 2;
  localparam int CTRL_SVC = 3;
  localparam int CTRL_PCMD = 4;
  localparam int RES_SPD_LSB = 4;
  localparam int QTH_OFF_LSB = 8;
  localparam int STAT_Q_LSB = 8;
  // Reset values
  localparam logic [5:0] DEPTH_DEF = 6'h08;
  localparam logic [5:0] AVG_DEF = 6'h08;
  localparam int AVG_MAX = 32;
  localparam logic [15:0] EDLY_DEF = 16'h0032;
  localparam logic [6:0] QWARN_DEF = 7'h3C;
  localparam logic [6:0] QOFF_DEF = 7'h1E;
  // Position and speed resolution codes and divisors, on the 0.01 unit base for position and the 1 mm/s base for speed
  localparam logic [2:0] PRES_0P01 = 3'h0;
  localparam logic [2:0] PRES_0P1 = 3'h1;
  localparam logic [2:0] PRES_1 = 3'h2;
  localparam logic [2:0] PRES_10 = 3'h3;
  localparam logic [1:0] SRES_1 = 2'h0;
  localparam logic [1:0] SRES_10 = 2'h1;
  localparam logic [1:0] SRES_100 = 2'h2;
  localparam logic [15:0] DV1 = 16'h0001;
  localparam logic [15:0] DV10 = 16'h000A;
  localparam logic [15:0] DV100 = 16'h0064;
  localparam logic [15:0] DV1000 = 16'h03E8;
  // Unit conversion, Q16 multipliers; raw input is 0.01 mm
  localparam int BASE_PER_UNIT = 100;
  localparam int POS_MUL_MM = 65536;
  localparam int POS_MUL_IN = 258016;
  localparam int SPD_MUL_MM = 655360;
  localparam int SPD_MUL_IN = 2580152;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Error handling states
  typedef enum logic [1:0] {
    ST_OK = 2'b00,
    ST_HOLD = 2'b01,
    ST_FAIL = 2'b10
  } psp_err_t;
endpackage : psp_pkg

// >>> verilog/psp_proc.sv
// Position and speed output processing with AXI4-Lite parameter registers
// Operation
// [RQ1] A new raw measurement is taken every millisecond, 1000 per second.
// [RQ2] Position is the mean of a configurable count of samples, default eight.
// [RQ3] With offset enabled, the fixed offset is added to the position.
// [RQ4] A preset event from input pin or bus command adopts the preset position.
// [RQ5] Preset correction wins over offset when both are enabled.
// [RQ6] Host position uses resolution 0.01, 0.1, 1, 10 or free; parameters unscaled.
// [RQ7] Position, speed and parameters use millimetres or hundredths of an inch.
// [RQ8] Speed is derived from successive positions and output with them.
// [RQ9] Speed output uses resolution 1, 10, 100 mm/s or free.
// [RQ10] Speed values are averaged over 1 to 32 milliseconds.
// [RQ11] Within the error delay the last valid values keep being output.
// [RQ12] After the error delay expires the substitute error values are output.
// [RQ13] Reading quality is a percentage; slightly under full scale is normal.
// [RQ14] Quality below the warning threshold, default 60 percent, raises a warning.
// [RQ15] Quality below the switch-off threshold, default 30 percent, is flagged.
// [RQ16] A position output at zero percent quality stays valid.
// [RQ17] Distance from read head to tape is reported.
// [RQ18] Tape distance is available only in service mode.
// [RQ19] The controller writes parameters addressed by object index.
// [RQ20] Reading quality is readable over the bus and on the display port.
// [RQ21] Smoothing is a running mean over the most recent samples.
// [RQ22] Error delay timer clears on valid data, starts at first invalid one.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps

module psp_mean import psp_pkg::*; #(
  parameter int DEPTH = 32,
  parameter int W = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sample stream
  input wire logic clr,
  input wire logic push,
  input wire logic signed [W-1:0] din,
  input wire logic [5:0] n,
  // Result
  output logic signed [W-1:0] mean
);
  localparam int AW = $clog2(DEPTH);
  logic signed [W-1:0] hist [DEPTH];
  logic [AW-1:0] wp_r;
  logic [5:0] fill_r;
  logic [5:0] n_r;
  logic signed [W+AW:0] sum_r;
  logic [AW-1:0] old_idx;
  logic signed [W+AW:0] old_v;

  // With n equal to DEPTH the index wraps onto the slot being overwritten
  assign old_idx = wp_r - AW'(n);
  assign old_v = (fill_r >= n) ? (W+AW+1)'(hist[old_idx]) : '0;

  always_ff @(posedge aclk) begin
    if (push) begin
      hist[wp_r] <= din;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      n_r <= 6'h00;
    end else begin
      n_r <= n;
    end
  end

  // A changed window length restarts the sum to keep it consistent
  always_ff @(posedge aclk) begin
    if (!aresetn || clr || n != n_r) begin
      wp_r <= '0;
      fill_r <= 6'h00;
      sum_r <= '0;
    end else if (push) begin // see [RQ21]
      wp_r <= wp_r + 1'b1;
      sum_r <= sum_r + (W+AW+1)'(din) - old_v;
      if (fill_r < n) begin
        fill_r <= fill_r + 6'h01;
      end
    end
  end

  assign mean = (fill_r == 6'h00) ? '0 : W'(sum_r / $signed({1'b0, fill_r}));
endmodule : psp_mean

module psp_proc import psp_pkg::*; #(
  parameter int MS_CYC = MS_CYCLES,
  parameter int MAX_DEPTH = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Optical front end
  output logic meas_tick,
  input wire logic signed [31:0] raw_pos,
  input wire logic raw_ok,
  input wire logic [6:0] raw_quality,
  input wire logic [15:0] raw_dist,
  // Preset switching input
  input wire logic preset_in,
  // Process outputs
  output logic signed [31:0] pos_out,
  output logic signed [31:0] spd_out,
  output logic out_upd,
  output logic err_out,
  output logic [6:0] qual_out,
  output logic qual_warn,
  output logic qual_off,
  output logic [15:0] dist_out
);
  localparam int DIV_W = $clog2(MS_CYC);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYC - 1);

  if (MAX_DEPTH < 2 || MAX_DEPTH > 32 || (MAX_DEPTH & (MAX_DEPTH - 1)) != 0) begin : g_chk_d
    $error("MAX_DEPTH must be a power of two from 2 to 32");
  end
  if (MS_CYC < 2) begin : g_chk_c
    $error("MS_CYC must be at least 2");
  end

  // Configuration and state
  logic [3:0] ctrl_r;
  logic [2:0] pres_r;
  logic [1:0] sres_r;
  logic [5:0] depth_r, avg_r;
  logic signed [31:0] ofs_r, pre_r, perr_r, serr_r, pcorr_r, pprev_r;
  logic [15:0] edly_r, fpd_r, fsd_r, ecnt_r, dist_r;
  logic [6:0] qwarn_r, qoff_r;
  logic [DIV_W-1:0] div_r;
  logic t1_r, t2_r, ok_r, prev_ok_r, pin_r;
  psp_err_t st_r;
  logic signed [31:0] pmean, smean, pbase, sbase, pcorr_sel, ptot;
  logic [15:0] pdv, sdv;
  logic aw_go, pre_evt, mclr, inch;
  logic [32:0] wr_old, rd_now;
  logic [31:0] wd;

  function automatic logic [5:0] clamp_n(input logic [5:0] v, input logic [5:0] mx);
    if (v == 6'h00) begin
      return 6'h01;
    end else if (v > mx) begin
      return mx;
    end
    return v;
  endfunction : clamp_n

  // Unit conversion in Q16
  function automatic logic signed [31:0] conv(input logic signed [31:0] v, input int m);
    logic signed [63:0] p;
    p = 64'(v) * 64'(m);
    return 32'(p >>> 16);
  endfunction : conv

  // Zero divisor is taken as one so a stray free setting cannot stall output
  function automatic logic signed [31:0] sdiv(input logic signed [31:0] v,
                                              input logic [15:0] d);
    logic signed [31:0] dd;
    dd = (d == 16'h0000) ? 32'sh1 : $signed({16'h0000, d});
    return v / dd;
  endfunction : sdiv

  function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        o[8*i +: 8] = n[8*i +: 8];
      end
    end
    return o;
  endfunction : wmask

  // Bit 32 marks a mapped address
  function automatic logic [32:0] rd_word(input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      ADDR_CTRL: v = 32'(ctrl_r);
      ADDR_RES: begin
        v[2:0] = pres_r;
        v[RES_SPD_LSB +: 2] = sres_r;
      end
      ADDR_DEPTH: v = 32'(depth_r);
      ADDR_AVG: v = 32'(avg_r);
      ADDR_OFS: v = ofs_r;
      ADDR_PRE: v = pre_r;
      ADDR_EDLY: v = 32'(edly_r);
      ADDR_PERR: v = perr_r;
      ADDR_SERR: v = serr_r;
      ADDR_QTH: begin
        v[6:0] = qwarn_r;
        v[QTH_OFF_LSB +: 7] = qoff_r;
      end
      ADDR_FPD: v = 32'(fpd_r);
      ADDR_FSD: v = 32'(fsd_r);
      ADDR_STAT: v = {17'h00000, qual_out, 3'h0, qual_off, qual_warn, st_r, 1'b0} >> 1;
      ADDR_POS: v = pos_out;
      ADDR_SPD: v = spd_out;
      ADDR_DIST: v = 32'(dist_out);
      default: return {1'b0, 32'h0000_0000};
    endcase
    return {1'b1, v};
  endfunction : rd_word

  // Millisecond measurement strobe
  always_ff @(posedge aclk) begin
    if (!aresetn || div_r == DIV_LAST) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end
  assign meas_tick = (div_r == DIV_LAST); // see [RQ1]

  // Register bus: address and data taken together once both are offered
  assign aw_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = aw_go;
  assign s_axi_wready = aw_go;
  assign s_axi_arready = ~s_axi_rvalid;
  // A process, not an assign, so register changes re-run the lookup
  always_comb begin
    wr_old = rd_word(s_axi_awaddr);
    rd_now = rd_word(s_axi_araddr);
  end
  assign wd = wmask(wr_old[31:0], s_axi_wdata, s_axi_wstrb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (aw_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_old[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin // see [RQ20]
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_now[31:0];
      s_axi_rresp <= rd_now[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Parameter objects written by the controller
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= 4'h0;
      pres_r <= PRES_0P01;
      sres_r <= SRES_1;
      depth_r <= DEPTH_DEF;
      avg_r <= AVG_DEF;
      ofs_r <= 32'sh0;
      pre_r <= 32'sh0;
      edly_r <= EDLY_DEF;
      perr_r <= 32'sh0;
      serr_r <= 32'sh0;
      qwarn_r <= QWARN_DEF;
      qoff_r <= QOFF_DEF;
      fpd_r <= DV1;
      fsd_r <= DV1;
    end else if (aw_go) begin // see [RQ19]
      case (s_axi_awaddr)
        ADDR_CTRL: ctrl_r <= wd[3:0];
        ADDR_RES: begin
          pres_r <= wd[2:0];
          sres_r <= wd[RES_SPD_LSB +: 2];
        end
        ADDR_DEPTH: depth_r <= wd[5:0];
        ADDR_AVG: avg_r <= wd[5:0];
        ADDR_OFS: ofs_r <= wd;
        ADDR_PRE: pre_r <= wd;
        ADDR_EDLY: edly_r <= wd[15:0];
        ADDR_PERR: perr_r <= wd;
        ADDR_SERR: serr_r <= wd;
        ADDR_QTH: begin
          qwarn_r <= wd[6:0];
          qoff_r <= wd[QTH_OFF_LSB +: 7];
        end
        ADDR_FPD: fpd_r <= wd[15:0];
        ADDR_FSD: fsd_r <= wd[15:0];
        default: ;
      endcase
    end
  end

  // Position smoothing and speed averaging
  assign mclr = meas_tick && !raw_ok && ecnt_r >= edly_r && st_r != ST_FAIL;

  psp_mean #(.DEPTH(MAX_DEPTH), .W(32)) u_pos_mean ( // see [RQ2]
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(mclr),
    .push(meas_tick && raw_ok),
    .din(raw_pos),
    .n(clamp_n(depth_r, 6'(MAX_DEPTH))),
    .mean(pmean)
  );

  psp_mean #(.DEPTH(AVG_MAX), .W(32)) u_spd_mean ( // see [RQ10]
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(mclr),
    .push(t1_r && ok_r && prev_ok_r),
    .din(pmean - pprev_r),
    .n(clamp_n(avg_r, 6'(AVG_MAX))),
    .mean(smean)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t1_r <= 1'b0;
      t2_r <= 1'b0;
      ok_r <= 1'b0;
      prev_ok_r <= 1'b0;
      pprev_r <= 32'sh0;
    end else begin
      t1_r <= meas_tick;
      t2_r <= t1_r;
      if (meas_tick) begin
        ok_r <= raw_ok;
      end
      if (t1_r) begin // see [RQ8]
        prev_ok_r <= ok_r;
        if (ok_r) begin
          pprev_r <= pmean;
        end
      end
    end
  end

  // Unit, correction and resolution
  assign inch = ctrl_r[CTRL_INCH];
  assign pbase = conv(pmean, inch ? POS_MUL_IN : POS_MUL_MM); // see [RQ7]
  assign sbase = conv(smean, inch ? SPD_MUL_IN : SPD_MUL_MM);
  assign pre_evt = (preset_in && !pin_r) || (aw_go && s_axi_awaddr == ADDR_CTRL &&
                                              wd[CTRL_PCMD]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_r <= 1'b0;
      pcorr_r <= 32'sh0;
    end else begin
      pin_r <= preset_in;
      if (pre_evt) begin // see [RQ4]
        pcorr_r <= 32'(pre_r * BASE_PER_UNIT) - pbase;
      end
    end
  end

  always_comb begin
    if (ctrl_r[CTRL_PRE_EN]) begin // see [RQ5]
      pcorr_sel = pcorr_r;
    end else if (ctrl_r[CTRL_OFS_EN]) begin // see [RQ3]
      pcorr_sel = 32'(ofs_r * BASE_PER_UNIT);
    end else begin
      pcorr_sel = 32'sh0;
    end
    ptot = pbase + pcorr_sel;
    case (pres_r) // see [RQ6]
      PRES_0P01: pdv = DV1;
      PRES_0P1: pdv = DV10;
      PRES_1: pdv = DV100;
      PRES_10: pdv = DV1000;
      default: pdv = fpd_r;
    endcase
    case (sres_r) // see [RQ9]
      SRES_1: sdv = DV1;
      SRES_10: sdv = DV10;
      SRES_100: sdv = DV100;
      default: sdv = fsd_r;
    endcase
  end

  // Error delay handling per measurement
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_OK;
      ecnt_r <= 16'h0000;
    end else if (meas_tick) begin
      if (raw_ok) begin // see [RQ22]
        st_r <= ST_OK;
        ecnt_r <= 16'h0000;
      end else begin
        st_r <= (ecnt_r >= edly_r) ? ST_FAIL : ST_HOLD;
        if (ecnt_r != 16'hFFFF) begin
          ecnt_r <= ecnt_r + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_out <= 32'sh0;
      spd_out <= 32'sh0;
      out_upd <= 1'b0;
      err_out <= 1'b0;
    end else begin
      out_upd <= t2_r;
      if (t2_r) begin
        err_out <= (st_r == ST_FAIL);
        case (st_r)
          ST_OK: begin
            pos_out <= sdiv(ptot, pdv);
            spd_out <= sdiv(sbase, sdv);
          end
          ST_FAIL: begin // see [RQ12]
            pos_out <= perr_r;
            spd_out <= serr_r;
          end
          default: ; // Last valid values held, see [RQ11]
        endcase
      end
    end
  end

  // Quality grading; the switch-off flag never invalidates a position
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qual_out <= 7'h00;
      qual_warn <= 1'b0;
      qual_off <= 1'b0;
      dist_r <= 16'h0000;
      dist_out <= 16'h0000;
    end else begin
      dist_out <= ctrl_r[CTRL_SVC] ? dist_r : 16'h0000; // see [RQ18]
      if (meas_tick) begin
        qual_out <= raw_quality; // see [RQ13]
        qual_warn <= raw_quality < qwarn_r; // see [RQ14]
        qual_off <= raw_quality < qoff_r; // see [RQ15]
        dist_r <= raw_dist; // see [RQ17]
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] gap_r;
  logic seen_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= 32'h0000_0000;
      seen_r <= 1'b0;
    end else begin
      gap_r <= meas_tick ? 32'h0000_0000 : gap_r + 32'h0000_0001;
      seen_r <= seen_r | meas_tick;
    end
  end

  a_tick_period: // see [RQ1]
    assert property (meas_tick && seen_r |-> gap_r == 32'(MS_CYC - 1))
    else $error("measurement strobe spacing wrong");
  a_hold_last: // see [RQ11]
    assert property (t2_r && st_r == ST_HOLD |=> $stable(pos_out) && $stable(spd_out))
    else $error("output changed during error delay");
  a_fail_subst: // see [RQ12]
    assert property (t2_r && st_r == ST_FAIL |=> pos_out == $past(perr_r) &&
                     spd_out == $past(serr_r))
    else $error("substitute values not output");
  a_ecnt_clear: // see [RQ22]
    assert property (meas_tick && raw_ok |=> ecnt_r == 16'h0000 && st_r == ST_OK)
    else $error("error timer not cleared by valid sample");
  a_warn_flag: // see [RQ14]
    assert property (meas_tick |=> qual_warn == ($past(raw_quality) < $past(qwarn_r)))
    else $error("quality warning wrong");
  a_off_flag: // see [RQ15]
    assert property (meas_tick ##1 qual_off |-> $past(raw_quality) < $past(qoff_r))
    else $error("switch-off flag wrong");
  a_dist_gate: // see [RQ18]
    assert property (!ctrl_r[CTRL_SVC] [*2] |-> dist_out == 16'h0000)
    else $error("distance shown outside service mode");
  a_offset_add: // see [RQ3]
    assert property (t2_r && st_r == ST_OK && ctrl_r == 4'h1 && pres_r == PRES_0P01
                     |=> pos_out == $past(pmean) + 32'($past(ofs_r) * BASE_PER_UNIT))
    else $error("offset not added");
  a_preset_take: // see [RQ4]
    assert property (pre_evt && !meas_tick |=> pbase + pcorr_r ==
                     32'($past(pre_r) * BASE_PER_UNIT))
    else $error("preset not adopted");
  a_zero_qual: // see [RQ16]
    assert property (meas_tick && raw_ok && raw_quality == 7'h00 |=> st_r == ST_OK)
    else $error("zero quality sample rejected");
endmodule : psp_proc
